/* verilog/scx_defines.svh */
// Constants for the sensor CPU execution unit.
`ifndef SCX_DEFINES_SVH
`define SCX_DEFINES_SVH

// ----------------------------------------------------------------
// Operation nibbles
// ----------------------------------------------------------------
`define SCX_OP_LOAD_IMM   4'h0
`define SCX_OP_CLEAR      4'h1
`define SCX_OP_AND        4'h2
`define SCX_OP_OR         4'h3
`define SCX_OP_ADD        4'h4
`define SCX_OP_STORE      4'h5
`define SCX_OP_SHIFT_L    4'h6
`define SCX_OP_SHIFT_R    4'h7
`define SCX_OP_INC        4'h8
`define SCX_OP_DEC        4'h9
`define SCX_OP_INVERT     4'ha
`define SCX_OP_BRANCH_NN  4'hb

// ----------------------------------------------------------------
// Register addresses with a fixed role
// ----------------------------------------------------------------
`define SCX_ACC_SEL       4'h1
`define SCX_IDX_SEL       4'h5
`define SCX_CARRY_TGT_SEL 4'h6
`define SCX_CARRY_SRC_SEL 4'h4

// ----------------------------------------------------------------
// Reset values and fixed steps
// ----------------------------------------------------------------
`define SCX_PC_RST        16'h0000
`define SCX_REG_RST       16'h0000
`define SCX_CLEAR_VAL     16'h0000
`define SCX_PC_STEP       16'h0001
`define SCX_REG_STEP      16'h0001
`define SCX_SIGN_BIT      15

`endif

/* verilog/scx_pkg.sv */
// Types shared by the sensor CPU execution unit.
package scx_pkg;

  // ----------------------------------------------------------------
  // Instruction byte: operation in the high nibble, register below.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] sel;
  } scx_instr_t;

  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCX_ST_EXEC,
    SCX_ST_IMM_HI,
    SCX_ST_IMM_LO
  } scx_state_t;

  // ----------------------------------------------------------------
  // Per-instruction status pulses.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic retire;
    logic taken;
    logic unsupported;
  } scx_status_t;

endpackage : scx_pkg

/* verilog/scx_exec.sv */
// Execution unit for the sensor CPU instructions, one byte each except the three-byte load.
`timescale 1ns/100ps
`include "scx_defines.svh"

module scx_exec #(
  parameter int unsigned NUM_REGS = 16  // Size of the register file.
) (
  input  wire logic               mclk_i,        // 40 MHz clock.
  input  wire logic               sys_rst_i,     // Sync reset, high.
  input  wire logic               run_i,         // Run request, async.
  input  wire logic               fetch_valid_i, // Flash byte valid.
  input  wire scx_pkg::scx_instr_t fetch_data_i, // Byte at fetch_addr_o.
  input  wire logic [3:0]         dbg_sel_i,     // Register to observe.
  output logic [15:0]             fetch_addr_o,  // Program counter.
  output logic                    fetch_req_o,   // Fetch wanted.
  output logic [15:0]             acc_o,         // Accumulator copy.
  output logic [15:0]             dbg_data_o,    // Observed register.
  output scx_pkg::scx_status_t    status_o       // Status pulses.
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Left shift; the caller supplies the bit that enters bit 0.
  function automatic logic [15:0] shl_f(
    input logic [15:0] v,
    input logic        fill
  );
    shl_f = {v[14:0], fill};
  endfunction : shl_f

  // Arithmetic right shift by one; bit 15 stays and copies down.
  function automatic logic [15:0] sar_f(input logic [15:0] v);
    sar_f = {v[15], v[15:1]};
  endfunction : sar_f

  // Sum cut to 16 bits; any carry out is dropped on purpose.
  function automatic logic [15:0] add16_f(
    input logic [15:0] a,
    input logic [15:0] b
  );
    add16_f = a + b;
  endfunction : add16_f

  // Sequential step of the program counter, wrapping at 16 bits.
  function automatic logic [15:0] step_f(input logic [15:0] p);
    step_f = add16_f(p, `SCX_PC_STEP);
  endfunction : step_f

  // ----------------------------------------------------------------
  // Run request synchroniser
  // ----------------------------------------------------------------

  logic run_meta_r;
  logic run_meta_nxt;
  logic run_sync_r;
  logic run_sync_nxt;

  // The run level comes from the serial side, so it is resampled
  // twice before the sequencer may look at it. Only the second
  // stage is read by logic; the first may still be settling.
  always_comb
  begin
    run_meta_nxt = run_i;
    run_sync_nxt = run_meta_r;
  end

  // Synchroniser flops.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      run_meta_r <= 1'b0;
      run_sync_r <= 1'b0;
    end
    else
    begin
      run_meta_r <= run_meta_nxt;
      run_sync_r <= run_sync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------

  logic [15:0]         regs_r   [NUM_REGS];
  logic [15:0]         regs_nxt [NUM_REGS];
  logic [15:0]         pc_r;
  logic [15:0]         pc_nxt;
  scx_pkg::scx_state_t state_r;
  scx_pkg::scx_state_t state_nxt;
  logic [3:0]          ld_sel_r;
  logic [3:0]          ld_sel_nxt;
  logic [7:0]          ld_hi_r;
  logic [7:0]          ld_hi_nxt;
  scx_pkg::scx_status_t st_r;
  scx_pkg::scx_status_t st_nxt;

  logic                take;
  logic [15:0]         opnd;
  logic [15:0]         acc;
  logic [15:0]         idx;
  logic [15:0]         carry_src;

  // A byte is consumed only while running and the flash has it.
  assign take = run_sync_r & fetch_valid_i;

  // Operand reads shared by the decoder below.
  // any register as operand
  assign opnd      = regs_r[fetch_data_i.sel];
  assign acc       = regs_r[`SCX_ACC_SEL];
  assign idx       = regs_r[`SCX_IDX_SEL];
  assign carry_src = regs_r[`SCX_CARRY_SRC_SEL];

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------

  // Next values of registers, counter and sequencer. Only one register,
  // the one named or the accumulator for AND, OR and ADD, is written in any cycle.
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      regs_nxt[i] = regs_r[i];
    end
    pc_nxt     = pc_r;
    state_nxt  = state_r;
    ld_sel_nxt = ld_sel_r;
    ld_hi_nxt  = ld_hi_r;
    st_nxt     = '0;

    if (take)
    begin
      unique case (state_r)
        scx_pkg::SCX_ST_EXEC:
        begin
          pc_nxt        = step_f(pc_r);
          st_nxt.retire = 1'b1;
          unique case (fetch_data_i.opcode)
            `SCX_OP_LOAD_IMM:
            begin
              ld_sel_nxt    = fetch_data_i.sel;
              state_nxt     = scx_pkg::SCX_ST_IMM_HI;
              st_nxt.retire = 1'b0;
            end
            `SCX_OP_CLEAR:
            begin
              regs_nxt[fetch_data_i.sel] = `SCX_CLEAR_VAL;
            end
            `SCX_OP_AND:
            begin
              regs_nxt[`SCX_ACC_SEL] = acc & opnd;
            end
            `SCX_OP_OR:
            begin
              regs_nxt[`SCX_ACC_SEL] = acc | opnd;
            end
            `SCX_OP_ADD:
            begin
              regs_nxt[`SCX_ACC_SEL] = add16_f(acc, opnd);
            end
            `SCX_OP_STORE:
            begin
              regs_nxt[fetch_data_i.sel] = acc;
            end
            `SCX_OP_SHIFT_L:
            begin
              if (fetch_data_i.sel == `SCX_CARRY_TGT_SEL)
              begin
                regs_nxt[fetch_data_i.sel] =
                  shl_f(opnd, carry_src[`SCX_SIGN_BIT]);
              end
              else
              begin
                regs_nxt[fetch_data_i.sel] = shl_f(opnd, 1'b0);
              end
            end
            `SCX_OP_SHIFT_R:
            begin
              regs_nxt[fetch_data_i.sel] = sar_f(opnd);
            end
            `SCX_OP_INC:
            begin
              regs_nxt[fetch_data_i.sel] = add16_f(opnd, `SCX_REG_STEP);
            end
            `SCX_OP_DEC:
            begin
              regs_nxt[fetch_data_i.sel] = opnd - `SCX_REG_STEP;
            end
            `SCX_OP_INVERT:
            begin
              regs_nxt[fetch_data_i.sel] = ~opnd;
            end
            `SCX_OP_BRANCH_NN:
            begin
              if (!idx[`SCX_SIGN_BIT])
              begin
                pc_nxt       = add16_f(pc_r, opnd);
                st_nxt.taken = 1'b1;
              end
            end
            default:
            begin
              // Opcodes handled by other units: step over them and
              // report, so a missing unit is visible rather than hung.
              st_nxt.unsupported = 1'b1;
            end
          endcase
        end
        scx_pkg::SCX_ST_IMM_HI:
        begin
          ld_hi_nxt = fetch_data_i;
          pc_nxt    = step_f(pc_r);
          state_nxt = scx_pkg::SCX_ST_IMM_LO;
        end
        scx_pkg::SCX_ST_IMM_LO:
        begin
          regs_nxt[ld_sel_r] = {ld_hi_r, fetch_data_i};
          pc_nxt             = step_f(pc_r);
          state_nxt          = scx_pkg::SCX_ST_EXEC;
          st_nxt.retire      = 1'b1;
        end
      endcase
    end
  end

  // Registers of the execution state.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= `SCX_REG_RST;
      end
      pc_r     <= `SCX_PC_RST;
      state_r  <= scx_pkg::SCX_ST_EXEC;
      ld_sel_r <= 4'h0;
      ld_hi_r  <= 8'h00;
      st_r     <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= regs_nxt[i];
      end
      pc_r     <= pc_nxt;
      state_r  <= state_nxt;
      ld_sel_r <= ld_sel_nxt;
      ld_hi_r  <= ld_hi_nxt;
      st_r     <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Observation outputs
  // ----------------------------------------------------------------

  logic [15:0] dbg_r;
  logic [15:0] dbg_nxt;
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;

  // Copies are taken from the next state so they match the
  // architectural registers in the same cycle; a cycle of lag here
  // would confuse anyone single-stepping the core.
  always_comb
  begin
    dbg_nxt = regs_nxt[dbg_sel_i];
    acc_nxt = regs_nxt[`SCX_ACC_SEL];
  end

  // Output flops.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      dbg_r <= `SCX_REG_RST;
      acc_r <= `SCX_REG_RST;
    end
    else
    begin
      dbg_r <= dbg_nxt;
      acc_r <= acc_nxt;
    end
  end

  // Every output is a flop. The fetch request is the second
  // synchroniser stage itself, so the flash and the sequencer agree
  // on the very edge at which a byte is taken.
  assign fetch_addr_o = pc_r;
  assign fetch_req_o  = run_sync_r;
  assign acc_o        = acc_r;
  assign dbg_data_o   = dbg_r;
  assign status_o     = st_r;

endmodule : scx_exec

/* verification/scx_exec_asserts.sv */
// Port checker of the execution unit, bound to its top module.
`timescale 1ns/100ps
`include "scx_defines.svh"

module scx_exec_asserts #(
  parameter int unsigned NUM_REGS = 16  // Size of the register file.
) (
  input wire logic                 mclk_i,        // Clock.
  input wire logic                 sys_rst_i,     // Reset.
  input wire logic                 run_i,         // Run request.
  input wire logic                 fetch_valid_i, // Byte valid.
  input wire scx_pkg::scx_instr_t  fetch_data_i,  // Fetched byte.
  input wire logic [3:0]           dbg_sel_i,     // Observe select.
  input wire logic [15:0]          fetch_addr_o,  // Program counter.
  input wire logic                 fetch_req_o,   // Fetch wanted.
  input wire logic [15:0]          acc_o,         // Accumulator.
  input wire logic [15:0]          dbg_data_o,    // Observed register.
  input wire scx_pkg::scx_status_t status_o       // Status pulses.
);
  logic [1:0] imm_r;
  logic [1:0] imm_nxt;
  logic       take;
  logic       is_op;
  logic [3:0] op;

  // Immediate bytes must not be mistaken for instructions.
  always_comb
  begin
    take = fetch_req_o & fetch_valid_i;
    op = fetch_data_i.opcode;
    is_op = take && (imm_r == 2'h0);
    imm_nxt = imm_r;
    if (take)
      imm_nxt = is_op ? ((op == `SCX_OP_LOAD_IMM) ? 2'h2 : 2'h0)
                      : imm_r - 2'h1;
  end

  // The count is cleared by reset so a load cut short is forgotten.
  always_ff @(posedge mclk_i)
  begin
    imm_r <= sys_rst_i ? 2'h0 : imm_nxt;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  AST_PC_STEP: // step by one
    assert property (is_op && !(op inside {`SCX_OP_LOAD_IMM,
      `SCX_OP_BRANCH_NN}) |=> fetch_addr_o == $past(fetch_addr_o) + 16'h1)
    else $error("pc did not step by one");
  AST_BR_NOT: // untaken branch steps
    assert property (is_op && op == `SCX_OP_BRANCH_NN ##1 !status_o.taken
      |-> fetch_addr_o == $past(fetch_addr_o) + 16'h1)
    else $error("untaken branch pc wrong");
  AST_ACC_KEEP: // accumulator untouched
    assert property (is_op && !(op inside {[4'h2:4'h4]}) &&
      fetch_data_i.sel != `SCX_ACC_SEL |=> $stable(acc_o))
    else $error("accumulator changed");
  AST_IDLE: // nothing without a byte
    assert property (!take |=> $stable(acc_o) && $stable(fetch_addr_o)
      && status_o == 3'h0)
    else $error("state moved without a byte");
  AST_RETIRE: // one cycle
    assert property (is_op && op != `SCX_OP_LOAD_IMM |=> status_o.retire)
    else $error("no retire after one cycle");
  AST_LOAD_MID: // no early retire
    assert property (take && imm_r == 2'h2 |=> !status_o.retire &&
      fetch_addr_o == $past(fetch_addr_o) + 16'h1)
    else $error("load middle byte wrong");
  AST_LOAD_END: // third byte retires
    assert property (take && imm_r == 2'h1 |=> status_o.retire &&
      fetch_addr_o == $past(fetch_addr_o) + 16'h1)
    else $error("load end wrong");
  AST_CLEAR_ACC: // clear accumulator
    assert property (is_op && fetch_data_i == {`SCX_OP_CLEAR, `SCX_ACC_SEL}
      |=> acc_o == `SCX_CLEAR_VAL)
    else $error("accumulator not cleared");
  AST_INV_ACC: // invert accumulator
    assert property (is_op && fetch_data_i == {`SCX_OP_INVERT,
      `SCX_ACC_SEL} |=> acc_o == ~$past(acc_o))
    else $error("accumulator not inverted");

  cover property (is_op && op == `SCX_OP_BRANCH_NN ##1 status_o.taken);
  cover property (take && imm_r == 2'h1);
  cover property (is_op && op == 4'hc ##1 status_o.unsupported);
endmodule : scx_exec_asserts

bind scx_exec scx_exec_asserts #(.NUM_REGS(NUM_REGS)) scx_exec_asserts_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .run_i(run_i),
  .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
  .dbg_sel_i(dbg_sel_i), .fetch_addr_o(fetch_addr_o),
  .fetch_req_o(fetch_req_o), .acc_o(acc_o), .dbg_data_o(dbg_data_o),
  .status_o(status_o));

/* verification/scx_flash_model.sv */
// Behavioural flash program memory feeding the execution unit.
`timescale 1ns/100ps

module scx_flash_model (
  input  wire logic           mclk_i,    // Clock.
  input  wire logic [15:0]    addr_i,    // Byte address.
  input  wire logic           stall_i,   // Hold bytes back.
  input  wire logic           wr_i,      // Preload strobe.
  input  wire logic [7:0]     wr_addr_i, // Preload address.
  input  wire logic [7:0]     wr_data_i, // Preload byte.
  output logic                valid_o,   // Byte valid.
  output scx_pkg::scx_instr_t data_o     // Byte at addr_i.
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h5a;

  // Only 256 bytes are kept, so higher addresses alias onto them.
  always_ff @(posedge mclk_i)
  begin
    if (wr_i)
      mem[wr_addr_i] <= wr_data_i;
    if (valid_o)
      last_r <= mem[addr_i[7:0]];
  end

  // An idle bus shows the inverse of the last byte, never a stale copy.
  assign valid_o = !stall_i;
  assign data_o = valid_o ? mem[addr_i[7:0]] : ~last_r;
endmodule : scx_flash_model

/* verification/sensor_cpu_instruction_exec_bench.sv */
// Self-checking bench of the execution unit.
`timescale 1ns/100ps

module sensor_cpu_instruction_exec_bench;
  typedef struct packed {
    logic [7:0]  ins;
    logic [3:0]  sel;
    logic [15:0] val;
    logic [15:0] pc;
    logic [3:0]  st;
  } scx_row_t;
  logic                mclk_i;
  logic                sys_rst_i;
  logic                run_i;
  logic                stall;
  logic                wr;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;
  logic [3:0]          dbg_sel;
  logic                fvalid;
  scx_pkg::scx_instr_t fdata;
  logic [15:0]         faddr;
  logic [15:0]         acc;
  logic [15:0]         dbg_data;
  logic [15:0]         pc;
  logic                req;
  scx_pkg::scx_status_t status;
  logic [3:0]          seen;
  scx_row_t            r;
  int                  num_errors = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  logic [7:0]          seq [5] = '{8'h01, 8'hff, 8'hfe, 8'h81, 8'h81};
  // Byte, register to observe, its value, pc after, then the status
  // seen after the byte: {fetch wanted, retire, taken, unsupported}.
  scx_row_t rows [30] = '{
    48'h04_4_0000_0001_8, 48'h80_4_0000_0002_8, 48'h01_4_8001_0003_c,
    48'h06_6_0000_0004_8, 48'h40_6_0000_0005_8, 48'h03_6_4003_0006_c,
    48'h66_6_8007_0007_c, 48'h64_4_0002_0008_c, 48'h76_6_c003_0009_c,
    48'h92_2_ffff_000a_c, 48'h82_2_0000_000b_c, 48'ha6_6_3ffc_000c_c,
    48'h46_1_3ffc_000d_c, 48'h34_1_3ffe_000e_c, 48'h26_1_3ffc_000f_c,
    48'ha1_1_c003_0010_c, 48'h41_1_8006_0011_c, 48'h57_7_8006_0012_c,
    // clear, unsupported byte, taken branch by zero
    48'h11_1_0000_0013_c, 48'hc0_4_0002_0014_d, 48'hb2_5_0000_0014_e,
    48'hb4_5_0000_0016_e, 48'h95_5_ffff_0017_c, 48'hb4_5_ffff_0018_c,
    48'h85_5_0000_0019_c, 48'h08_8_0000_001a_8, 48'hff_8_0000_001b_8,
    48'hf0_8_fff0_001c_c, 48'hb8_8_fff0_000c_e, 48'h8f_f_0001_000d_c
  };

  scx_exec #(.NUM_REGS(16)) scx_exec_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .run_i(run_i),
    .fetch_valid_i(fvalid), .fetch_data_i(fdata), .dbg_sel_i(dbg_sel),
    .fetch_addr_o(faddr), .fetch_req_o(req), .acc_o(acc),
    .dbg_data_o(dbg_data), .status_o(status));

  scx_flash_model scx_flash_model_inst (
    .mclk_i(mclk_i), .addr_i(faddr), .stall_i(stall), .wr_i(wr),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .valid_o(fvalid),
    .data_o(fdata));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic check_status(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t status %h want %h", $time, got, exp);
    end
  endtask : check_status

  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : load

  // Lets n bytes through back to back, then waits for them to land.
  task automatic fire(input int n);
    @(posedge mclk_i);
    stall <= 1'b0;
    repeat (n) @(posedge mclk_i);
    stall <= 1'b1;
    // Status pulses stand for one cycle only, so catch them here.
    #1;
    seen = {req, status};
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : fire

  // The observed register lags its select by one cycle.
  task automatic peek(input logic [3:0] s, input logic [15:0] e);
    @(posedge mclk_i);
    dbg_sel <= s;
    repeat (2) @(posedge mclk_i);
    #1;
    check(dbg_data, e);
  endtask : peek

  task automatic summarize;
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Free-running clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // A hang is cut short well past the expected run length.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      summarize();
    end
  end

  // Main sequence.
  initial
  begin
    sys_rst_i = 1'b1;
    run_i = 1'b0;
    stall = 1'b1;
    wr = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    dbg_sel = 4'h0;
    pc = 16'h0000;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    run_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 30; i++)
    begin
      r = rows[i];
      load(pc[7:0], r.ins);
      fire(1);
      peek(r.sel, r.val);
      check(faddr, r.pc);
      check_status(seen, r.st);
      pc = r.pc;
    end
    // Reset mid-run, then offer bytes while run is low.
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    run_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    fire(3);
    check(faddr, 16'h0000);
    check_status(seen, 4'h0);
    peek(4'h4, 16'h0000);
    // Load then two increments, all back to back, wrapping to zero.
    for (int j = 0; j < 5; j++)
      load(j[7:0], seq[j]);
    run_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    fire(5);
    check(acc, 16'h0000);
    check_status(seen, 4'hc);
    check(faddr, 16'h0005);
    summarize();
  end
endmodule : sensor_cpu_instruction_exec_bench
